// >>> design/iobds_code_map.sv
// switch to device code map with registered outputs
`timescale 1ns/1ps
module iobds_code_map (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [iobds_pkg::SW_W-1:0] code_switch,
   output logic [iobds_pkg::GRP_W-1:0] code_group_select,
   output iobds_pkg::iobds_codes_t unit_code,
   output iobds_pkg::iobds_mask_t unit_enable
);

   logic [iobds_pkg::GRP_W-1:0] next_group;
   iobds_pkg::iobds_codes_t next_code;
   iobds_pkg::iobds_mask_t next_enable;

   // =========================================================
   // group select and table lookup
   always_comb begin
      // the two upper switch bits pick one of four code groups
      next_group = code_switch[iobds_pkg::SW_W-1 -: iobds_pkg::GRP_W];
      case (next_group)
         2'h0: next_code = iobds_pkg::GROUP0_CODES;
         2'h1: next_code = iobds_pkg::GROUP1_CODES;
         2'h2: next_code = iobds_pkg::GROUP2_CODES;
         default: next_code = iobds_pkg::GROUP3_CODES;
      endcase
      next_enable = iobds_pkg::ENABLE_ROWS[code_switch];
   end

   // =========================================================
   // switch is static; a cycle of lag after a change is harmless
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         code_group_select <= '0;
         unit_code <= '0;
         unit_enable <= '0;
      end else begin
         code_group_select <= next_group;
         unit_code <= next_code;
         unit_enable <= next_enable;
      end
   end

endmodule // iobds_code_map

// >>> design/iobds_pkg.sv
// constants shared by the i/o bus device select block
package iobds_pkg;

   // =========================================================
   // sizes
   localparam int DEV_COUNT = 7;
   localparam int CODE_W = 6;
   localparam int BYTE_W = 8;
   localparam int SEL_W = 3;
   localparam int SW_W = 4;
   localparam int GRP_W = 2;
   localparam int SW_ROWS = 16;

   // =========================================================
   // device indices
   localparam int DEV_CLOCK = 0;
   localparam int DEV_READER = 1;
   localparam int DEV_PUNCH = 2;
   localparam int DEV_TTI_ONE = 3;
   localparam int DEV_TTO_ONE = 4;
   localparam int DEV_TTI_TWO = 5;
   localparam int DEV_TTO_TWO = 6;

   typedef logic [DEV_COUNT-1:0] iobds_mask_t;
   typedef logic [DEV_COUNT-1:0][CODE_W-1:0] iobds_codes_t;

   // devices that take output data: clock, punch, both teletype outs
   localparam iobds_mask_t OUT_CAPABLE = 7'h55;
   // devices that return input data: reader, punch status, teletype ins
   localparam iobds_mask_t IN_CAPABLE = 7'h2E;

   // =========================================================
   // device codes per group, index 6 (tto2) down to 0 (clock)
   // octal 14 12 13 10 11 50 51
   localparam iobds_codes_t GROUP0_CODES =
      {6'h29, 6'h28, 6'h09, 6'h08, 6'h0B, 6'h0A, 6'h0C};
   // octal -- 23 31 32 33 34 35
   localparam iobds_codes_t GROUP1_CODES =
      {6'h1D, 6'h1C, 6'h1B, 6'h1A, 6'h19, 6'h13, 6'h00};
   // octal -- 23 13 32 33 34 35
   localparam iobds_codes_t GROUP2_CODES =
      {6'h1D, 6'h1C, 6'h1B, 6'h1A, 6'h0B, 6'h13, 6'h00};
   // octal -- 12 13 50 51 32 33
   localparam iobds_codes_t GROUP3_CODES =
      {6'h1B, 6'h1A, 6'h29, 6'h28, 6'h0B, 6'h0A, 6'h00};

   // enable per switch setting, setting 15 first; bit 0 is the clock
   localparam logic [SW_ROWS-1:0][DEV_COUNT-1:0] ENABLE_ROWS = {
      7'h1E, 7'h7A, 7'h7C, 7'h7E, 7'h00, 7'h66, 7'h7C, 7'h7E,
      7'h02, 7'h06, 7'h78, 7'h7E, 7'h1F, 7'h7B, 7'h7D, 7'h7F};

   // =========================================================
   // select codes, index 6 down to 0; code 4 is the dummy
   localparam logic [DEV_COUNT-1:0][SEL_W-1:0] SEL_CODES =
      {3'h7, 3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0};
   localparam logic [SEL_W-1:0] SEL_NONE = 3'h4;

   // =========================================================
   // reset stretch timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESET_STRETCH_NS = 1000;
   localparam int STRETCH_W = 7;
   localparam logic [STRETCH_W-1:0] RESET_STRETCH_CYCLES =
      STRETCH_W'(RESET_STRETCH_NS / CLK_PERIOD_NS);

endpackage

// >>> design/iobds_select.sv
// device select, strobe steering and interrupt chain of the i/o board
`timescale 1ns/1ps
module iobds_select (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [iobds_pkg::SW_W-1:0] code_switch,
   input wire logic [iobds_pkg::CODE_W-1:0] device_select,
   input wire logic data_in_a_strobe,
   input wire logic data_out_a_strobe,
   input wire logic start_pulse,
   input wire logic clear_pulse,
   input wire logic bus_reset,
   input wire logic interrupt_acknowledge,
   input wire logic request_enable,
   input wire logic priority_chain_in,
   input wire logic channel_priority_in,
   input wire logic [iobds_pkg::DEV_COUNT-1:0] unit_done_set,
   input wire logic [iobds_pkg::DEV_COUNT-1:0] irq_mask,
   input wire logic [iobds_pkg::BYTE_W-1:0] reader_byte,
   input wire logic [iobds_pkg::BYTE_W-1:0] tti_one_byte,
   input wire logic [iobds_pkg::BYTE_W-1:0] tti_two_byte,
   input wire logic [iobds_pkg::BYTE_W-1:0] punch_status_byte,
   output logic [iobds_pkg::GRP_W-1:0] code_group_select,
   output logic [iobds_pkg::SEL_W-1:0] sel_code,
   output logic output_selected,
   output logic [iobds_pkg::DEV_COUNT-1:0] unit_out_strobe,
   output logic [iobds_pkg::DEV_COUNT-1:0] unit_in_strobe,
   output logic [iobds_pkg::DEV_COUNT-1:0] unit_started,
   output logic [iobds_pkg::DEV_COUNT-1:0] unit_done,
   output logic [iobds_pkg::DEV_COUNT-1:0] unit_clear,
   output logic start_or_clear,
   output logic clock_unit_reset,
   output logic [iobds_pkg::BYTE_W-1:0] bus_data_out,
   output logic bus_data_oe,
   output logic selected_busy,
   output logic selected_busy_oe,
   output logic selected_done,
   output logic selected_done_oe,
   output logic interrupt_request,
   output logic priority_chain_out,
   output logic channel_priority_chain
);

   // =========================================================
   // helpers
   // lowest index wins, so the clock has top interrupt priority
   function automatic logic [iobds_pkg::SEL_W:0] first_set(
      input logic [iobds_pkg::DEV_COUNT-1:0] v);
      logic [iobds_pkg::SEL_W:0] r;
      r = '0;
      for (int i = iobds_pkg::DEV_COUNT - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, iobds_pkg::SEL_W'(i)};
         end
      end
      return r;
   endfunction

   iobds_pkg::iobds_codes_t unit_code;
   iobds_pkg::iobds_mask_t unit_enable;
   iobds_pkg::iobds_mask_t hit;
   iobds_pkg::iobds_mask_t int_req;
   iobds_pkg::iobds_mask_t next_int_req;
   iobds_pkg::iobds_mask_t next_started;
   iobds_pkg::iobds_mask_t next_done;
   logic [iobds_pkg::SEL_W:0] hit_first;
   logic [iobds_pkg::SEL_W:0] req_first;
   logic hit_valid;
   logic [iobds_pkg::SEL_W-1:0] hit_idx;
   logic [iobds_pkg::SEL_W-1:0] next_sel_code;
   logic [iobds_pkg::BYTE_W-1:0] next_bus_data;
   logic next_bus_oe;
   logic next_sel_busy;
   logic next_sel_done;
   logic next_sel_oe;
   logic next_interrupt_request;
   logic [iobds_pkg::STRETCH_W-1:0] stretch;
   logic [iobds_pkg::STRETCH_W-1:0] next_stretch;
   logic next_clock_reset;

   // =========================================================
   // code map
   iobds_code_map u_code_map (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .code_switch(code_switch),
      .code_group_select(code_group_select),
      .unit_code(unit_code),
      .unit_enable(unit_enable)
   );

   // =========================================================
   // address match and strobe steering
   always_comb begin
      hit = '0;
      for (int d = 0; d < iobds_pkg::DEV_COUNT; d++) begin
         hit[d] = unit_enable[d] && (unit_code[d] == device_select);
      end
   end

   assign hit_first = first_set(hit);
   assign hit_valid = hit_first[iobds_pkg::SEL_W];
   assign hit_idx = hit_first[iobds_pkg::SEL_W-1:0];
   assign req_first = first_set(int_req);

   assign output_selected = |(hit & iobds_pkg::OUT_CAPABLE);
   assign unit_out_strobe =
      {iobds_pkg::DEV_COUNT{data_out_a_strobe}} &
      hit & iobds_pkg::OUT_CAPABLE;
   assign unit_in_strobe =
      {iobds_pkg::DEV_COUNT{data_in_a_strobe}} &
      hit & iobds_pkg::IN_CAPABLE;
   assign start_or_clear = start_pulse | clear_pulse;
   assign unit_clear =
      (hit & {iobds_pkg::DEV_COUNT{start_or_clear}}) |
      {iobds_pkg::DEV_COUNT{bus_reset}};
   // no local unit uses the data channel
   assign channel_priority_chain = channel_priority_in;
   assign priority_chain_out = priority_chain_in & ~(|int_req);

   // =========================================================
   // next state
   always_comb begin
      next_started = unit_started;
      next_done = unit_done;
      for (int d = 0; d < iobds_pkg::DEV_COUNT; d++) begin
         if (hit[d] && start_or_clear) begin
            next_started[d] = start_pulse;
            next_done[d] = 1'b0;
         end
         // a done event in the clearing cycle is kept
         if (unit_done_set[d]) begin
            next_started[d] = 1'b0;
            next_done[d] = 1'b1;
         end
      end
      // requests only move while the host enables them or a bus reset clears them
      next_int_req = int_req;
      if (request_enable) begin
         next_int_req = next_done & ~irq_mask;
      end
      next_stretch = stretch;
      if (bus_reset) begin
         next_started = '0;
         next_done = '0;
         next_int_req = '0;
         next_stretch = iobds_pkg::RESET_STRETCH_CYCLES;
      end else if (stretch != '0) begin
         next_stretch = stretch - 1'b1;
      end
      next_clock_reset = bus_reset || (stretch != '0);
      next_interrupt_request = |next_int_req;

      next_sel_code = hit_valid ?
         iobds_pkg::SEL_CODES[hit_idx] : iobds_pkg::SEL_NONE;
      next_sel_oe = hit_valid;
      next_sel_busy = hit_valid && unit_started[hit_idx];
      next_sel_done = hit_valid && unit_done[hit_idx];

      next_bus_data = '0;
      next_bus_oe = 1'b0;
      if (interrupt_acknowledge) begin
         if (priority_chain_in && req_first[iobds_pkg::SEL_W]) begin
            next_bus_oe = 1'b1;
            next_bus_data = iobds_pkg::BYTE_W'(
               unit_code[req_first[iobds_pkg::SEL_W-1:0]]);
         end
      end else if (data_in_a_strobe && hit_valid &&
                   iobds_pkg::IN_CAPABLE[hit_idx]) begin
         next_bus_oe = 1'b1;
         case (hit_idx)
            3'(iobds_pkg::DEV_READER): next_bus_data = reader_byte;
            3'(iobds_pkg::DEV_TTI_ONE): next_bus_data = tti_one_byte;
            3'(iobds_pkg::DEV_TTI_TWO): next_bus_data = tti_two_byte;
            default: next_bus_data = punch_status_byte;
         endcase
      end
   end

   // =========================================================
   // registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         unit_started <= '0;
         unit_done <= '0;
         int_req <= '0;
         stretch <= '0;
         clock_unit_reset <= 1'b0;
         interrupt_request <= 1'b0;
         sel_code <= iobds_pkg::SEL_NONE;
         selected_busy <= 1'b0;
         selected_done <= 1'b0;
         selected_busy_oe <= 1'b0;
         selected_done_oe <= 1'b0;
         bus_data_out <= '0;
         bus_data_oe <= 1'b0;
      end else begin
         unit_started <= next_started;
         unit_done <= next_done;
         int_req <= next_int_req;
         stretch <= next_stretch;
         clock_unit_reset <= next_clock_reset;
         interrupt_request <= next_interrupt_request;
         sel_code <= next_sel_code;
         selected_busy <= next_sel_busy;
         selected_done <= next_sel_done;
         selected_busy_oe <= next_sel_oe;
         selected_done_oe <= next_sel_oe;
         bus_data_out <= next_bus_data;
         bus_data_oe <= next_bus_oe;
      end
   end

endmodule // iobds_select

// >>> tb/iobds_host_model.sv
// host processor side of the parallel i/o bus
`timescale 1ns/1ps
module iobds_host_model (
   input wire logic clk_sys,
   output logic [5:0] device_select,
   output logic data_in_a_strobe,
   output logic data_out_a_strobe,
   output logic start_pulse,
   output logic clear_pulse,
   output logic bus_reset,
   output logic interrupt_acknowledge,
   output logic request_enable,
   output logic priority_chain_in,
   output logic channel_priority_in
);
   // ==========
   // bus cycle: one clock of levels, changed on the falling edge
   initial begin
      device_select = 6'h00;
      {request_enable, channel_priority_in, priority_chain_in,
         interrupt_acknowledge, bus_reset, clear_pulse, start_pulse,
         data_out_a_strobe, data_in_a_strobe} = 9'h000;
   end
   task put(input logic [5:0] c, input logic [8:0] f);
      @(negedge clk_sys);
      device_select = c;
      {request_enable, channel_priority_in, priority_chain_in,
         interrupt_acknowledge, bus_reset, clear_pulse, start_pulse,
         data_out_a_strobe, data_in_a_strobe} = f;
   endtask
endmodule // iobds_host_model

// >>> tb/iobds_select_props.sv
// concurrent checks on the ports of the device select block
`timescale 1ns/1ps
module iobds_select_props (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic data_in_a_strobe,
   input wire logic data_out_a_strobe,
   input wire logic start_pulse,
   input wire logic clear_pulse,
   input wire logic bus_reset,
   input wire logic channel_priority_in,
   input wire logic [iobds_pkg::DEV_COUNT-1:0] unit_out_strobe,
   input wire logic [iobds_pkg::DEV_COUNT-1:0] unit_in_strobe,
   input wire logic [iobds_pkg::DEV_COUNT-1:0] unit_started,
   input wire logic [iobds_pkg::DEV_COUNT-1:0] unit_clear,
   input wire logic [iobds_pkg::SEL_W-1:0] sel_code,
   input wire logic start_or_clear,
   input wire logic clock_unit_reset,
   input wire logic selected_busy_oe,
   input wire logic selected_done_oe,
   input wire logic interrupt_request,
   input wire logic priority_chain_out,
   input wire logic channel_priority_chain
);
   // ==========
   // assertions
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   soc_merge_a: assert property (
      start_or_clear == (start_pulse || clear_pulse))
      else $error("start or clear indication wrong");
   chan_pass_a: assert property (
      channel_priority_chain == channel_priority_in)
      else $error("channel priority not passed");
   chain_block_a: assert property (
      interrupt_request |-> !priority_chain_out)
      else $error("priority passed while requesting");
   out_steer_a: assert property (
      |unit_out_strobe |-> data_out_a_strobe && $onehot(unit_out_strobe)
      && (unit_out_strobe & ~iobds_pkg::OUT_CAPABLE) == '0)
      else $error("output strobe misrouted");
   in_steer_a: assert property (
      |unit_in_strobe |-> data_in_a_strobe && $onehot(unit_in_strobe)
      && (unit_in_strobe & ~iobds_pkg::IN_CAPABLE) == '0)
      else $error("input strobe misrouted");
   reset_clear_a: assert property (
      bus_reset |-> &unit_clear)
      else $error("bus reset did not clear all units");
   reset_flags_a: assert property (
      bus_reset |=> unit_started == '0 && !interrupt_request)
      else $error("flags survive bus reset");
   stretch_hold_a: assert property (
      bus_reset |=> clock_unit_reset [*8])
      else $error("clock unit reset not stretched");
   idle_sel_a: assert property (
      sel_code == iobds_pkg::SEL_NONE |-> !selected_busy_oe
      && !selected_done_oe)
      else $error("busy or done driven with no unit");
endmodule // iobds_select_props

bind iobds_select iobds_select_props chk_u (.clk_sys, .rst_n,
   .data_in_a_strobe, .data_out_a_strobe, .start_pulse, .clear_pulse,
   .bus_reset, .channel_priority_in, .unit_out_strobe, .unit_in_strobe,
   .unit_started, .unit_clear, .sel_code, .start_or_clear,
   .clock_unit_reset, .selected_busy_oe, .selected_done_oe,
   .interrupt_request, .priority_chain_out, .channel_priority_chain);

// >>> tb/tb_top.sv
// self-checking bench for the device select block
`timescale 1ns/1ps
module tb_top;
   // bit 8 request enable, bit 6 priority in
   localparam logic [8:0] B = 9'h140;
   localparam logic [5:0] C0 [7] = '{6'h0C, 6'h0A, 6'h0B, 6'h08, 6'h09,
      6'h28, 6'h29};
   localparam logic [2:0] SC [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5,
      3'h6, 3'h7};
   localparam logic [7:0] BY [7] = '{8'h00, 8'hA1, 8'hD4, 8'hB2, 8'h00,
      8'hC3, 8'h00};
   logic clk_sys, rst_n;
   logic [3:0] code_switch;
   logic [6:0] unit_done_set, irq_mask;
   logic [5:0] device_select;
   logic data_in_a_strobe, data_out_a_strobe, start_pulse, clear_pulse;
   logic bus_reset, interrupt_acknowledge, request_enable;
   logic priority_chain_in, channel_priority_in;
   logic [1:0] code_group_select;
   logic [2:0] sel_code;
   logic [6:0] unit_out_strobe, unit_in_strobe, unit_started;
   logic [6:0] unit_done, unit_clear;
   logic [7:0] bus_data_out;
   logic output_selected, start_or_clear, clock_unit_reset, bus_data_oe;
   logic selected_busy, selected_busy_oe, selected_done, selected_done_oe;
   logic interrupt_request, priority_chain_out, channel_priority_chain;
   int error_cnt = 0;
   int checks_done = 0;
   iobds_host_model host_u (.clk_sys, .device_select, .data_in_a_strobe,
      .data_out_a_strobe, .start_pulse, .clear_pulse, .bus_reset,
      .interrupt_acknowledge, .request_enable, .priority_chain_in,
      .channel_priority_in);
   iobds_select dut_u (.clk_sys, .rst_n, .code_switch, .device_select,
      .data_in_a_strobe, .data_out_a_strobe, .start_pulse, .clear_pulse,
      .bus_reset, .interrupt_acknowledge, .request_enable,
      .priority_chain_in, .channel_priority_in, .unit_done_set, .irq_mask,
      .reader_byte(8'hA1), .tti_one_byte(8'hB2), .tti_two_byte(8'hC3),
      .punch_status_byte(8'hD4), .code_group_select, .sel_code,
      .output_selected, .unit_out_strobe, .unit_in_strobe, .unit_started,
      .unit_done, .unit_clear, .start_or_clear, .clock_unit_reset,
      .bus_data_out, .bus_data_oe, .selected_busy, .selected_busy_oe,
      .selected_done, .selected_done_oe, .interrupt_request,
      .priority_chain_out, .channel_priority_chain);
   // ==========
   // helpers
   task chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task idle(input int n);
      repeat (n) host_u.put(6'h00, B);
   endtask
   task summarize;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==========
   // scenarios
   task s_map;
      for (int i = 0; i < 7; i++) begin
         host_u.put(C0[i], B | ((BY[i] != 0) ? 9'h001 : 9'h002));
         #1;
         chk(8'(unit_in_strobe | unit_out_strobe), 8'(1 << i));
         chk(8'(output_selected), 8'(i % 2 == 0));
         @(posedge clk_sys);
         #1;
         chk(8'(sel_code), 8'(SC[i]));
         if (BY[i] != 0) chk(bus_data_out, BY[i]);
      end
   endtask
   task s_group;
      @(negedge clk_sys) code_switch = 4'h1;
      idle(3);
      host_u.put(6'h0A, B | 9'h001);
      #1;
      chk(8'(unit_in_strobe), 8'h00);
      @(posedge clk_sys);
      #1;
      chk(8'(sel_code), 8'h04);
      chk(8'({selected_busy_oe, selected_done_oe}), 8'h00);
      @(negedge clk_sys) code_switch = 4'hC;
      idle(3);
      chk(8'(code_group_select), 8'h03);
      host_u.put(6'h28, B | 9'h001);
      #1;
      chk(8'(unit_in_strobe), 8'h08);
      @(negedge clk_sys) code_switch = 4'h0;
      idle(3);
   endtask
   task s_flow;
      host_u.put(6'h09, B | 9'h004);
      #1;
      chk(8'(unit_clear), 8'h10);
      chk(8'(start_or_clear), 8'h01);
      @(posedge clk_sys);
      #1;
      chk(8'(unit_started), 8'h10);
      host_u.put(6'h09, B);
      unit_done_set = 7'h10;
      host_u.put(6'h09, B);
      unit_done_set = 7'h00;
      host_u.put(6'h09, B);
      #1;
      chk(8'(unit_started), 8'h00);
      chk(8'(unit_done), 8'h10);
      chk(8'(interrupt_request), 8'h01);
      chk(8'(priority_chain_out), 8'h00);
      chk(8'({selected_busy, selected_done, selected_done_oe}), 8'h03);
      host_u.put(6'h00, B | 9'h020);
      @(posedge clk_sys);
      #1;
      chk({bus_data_oe, bus_data_out[6:0]}, 8'h89);
      idle(1);
      irq_mask = 7'h10;
      idle(2);
      chk(8'(interrupt_request), 8'h00);
      // unmask only once request enable is already low
      host_u.put(6'h00, 9'h040);
      irq_mask = 7'h00;
      host_u.put(6'h00, 9'h040);
      chk(8'(interrupt_request), 8'h00);
      idle(2);
      chk(8'(interrupt_request), 8'h01);
      host_u.put(6'h09, B | 9'h008);
      @(posedge clk_sys);
      #1;
      chk(8'(unit_done), 8'h00);
   endtask
   task s_reset;
      host_u.put(6'h00, B | 9'h090);
      #1;
      chk(8'(unit_clear), 8'h7F);
      chk(8'(channel_priority_chain), 8'h01);
      idle(50);
      chk(8'(clock_unit_reset), 8'h01);
      idle(60);
      chk(8'(clock_unit_reset), 8'h00);
      chk(8'(priority_chain_out), 8'h01);
   endtask
   // ==========
   // clock, stimulus and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #50000;
      error_cnt++;
      summarize();
   end
   initial begin
      rst_n = 1'b0;
      code_switch = 4'h0;
      unit_done_set = 7'h00;
      irq_mask = 7'h00;
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys) rst_n = 1'b1;
      idle(3);
      s_map();
      s_group();
      s_flow();
      s_reset();
      summarize();
   end
endmodule // tb_top
